// File: src/bssp_switch_port.sv
// Expander end: two register-pointer expanders driving switch enables
`timescale 1ns/1ps
`default_nettype none
`include "bssp_params.svh"

module bssp_switch_port
  import bssp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  bssp_i2c_if.dev bus,
  output logic [2:0] o_indicator_light,
  output logic o_flash_select_switch_enable,
  output logic o_flash_quad_lane_enable,
  output logic o_serial_bridge_enable,
  output logic o_serial_flow_control_enable,
  output logic o_card_bus_to_connector_enable,
  output logic o_card_bus_to_memory_enable,
  output logic [7:0] o_aux_port_a,
  output logic [7:0] o_aux_port_b
);
  bssp_dev_state_e state_reg;
  logic scl_q_reg;
  logic sda_q_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic sel_reg;
  logic rw_reg;
  logic nack_reg;
  logic oe_reg;
  logic [7:0] dir_reg [2][2];
  logic [7:0] lat_reg [2][2];
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic [1:0] hit;
  logic [7:0] rd_byte;
  logic wr_en;
  logic [7:0] pin_a0;
  logic [7:0] pin_b0;
  logic [7:0] pin_a1;
  logic [7:0] pin_b1;

  // ==========================================================
  // Helpers
  // Match against both expander addresses: {hit, select}
  function automatic logic [1:0] addr_hit(input logic [6:0] a);
    if (a == `BSSP_EXP0_ADDR) begin
      return 2'b10;
    end else if (a == `BSSP_EXP1_ADDR) begin
      return 2'b11;
    end else begin
      return 2'b00;
    end
  endfunction

  // Register read; unmapped pointers read zero
  function automatic logic [7:0] reg_read(input logic e,
                                          input logic [7:0] p);
    if (p == `BSSP_REG_DIR_A) begin
      return dir_reg[e][0];
    end else if (p == `BSSP_REG_DIR_B) begin
      return dir_reg[e][1];
    end else if (p == `BSSP_REG_LAT_A) begin
      return lat_reg[e][0];
    end else if (p == `BSSP_REG_LAT_B) begin
      return lat_reg[e][1];
    end else begin
      return 8'h00;
    end
  endfunction

  // Pin level: latch when output, board pull when input
  function automatic logic [7:0] pin_val(input logic [7:0] dir,
                                         input logic [7:0] lat,
                                         input logic [7:0] pull);
    return (~dir & lat) | (dir & pull);
  endfunction

  // ==========================================================
  // Bus sampling and event detect
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= bus.scl;
      sda_q_reg <= bus.sda;
    end
  end

  // Start and stop are data edges while clock is high
  assign scl_rise = bus.scl & ~scl_q_reg;
  assign scl_fall = ~bus.scl & scl_q_reg;
  assign start_ev = bus.scl & scl_q_reg & sda_q_reg & ~bus.sda;
  assign stop_ev = bus.scl & scl_q_reg & ~sda_q_reg & bus.sda;
  assign hit = addr_hit(shift_reg[7:1]);
  assign rd_byte = reg_read(sel_reg, ptr_reg);
  assign wr_en = (state_reg == d_wdata) && scl_fall && (cnt_reg == 4'h8)
                 && !start_ev && !stop_ev;

  // ==========================================================
  // Slave state machine
  // only bus transfers reach the registers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= d_idle;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      sel_reg <= 1'b0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (start_ev) begin
      state_reg <= d_addr;
      cnt_reg <= 4'h0;
      oe_reg <= 1'b0;
    end else if (stop_ev) begin
      state_reg <= d_idle;
      oe_reg <= 1'b0;
    end else begin
      // Shift in on rising clock
      if (scl_rise) begin
        if (state_reg == d_addr || state_reg == d_reg ||
            state_reg == d_wdata) begin
          shift_reg <= {shift_reg[6:0], bus.sda};
          cnt_reg <= cnt_reg + 4'h1;
        end
        if (state_reg == d_rdata) begin
          cnt_reg <= cnt_reg + 4'h1;
        end
        if (state_reg == d_rack) begin
          nack_reg <= bus.sda;
        end
      end
      // Drive and advance on falling clock
      if (scl_fall) begin
        case (state_reg)
          d_addr: begin
            if (cnt_reg == 4'h8) begin
              if (hit[1]) begin
                sel_reg <= hit[0];
                rw_reg <= shift_reg[0];
                oe_reg <= 1'b1;
                state_reg <= d_ack_a;
              end else begin
                state_reg <= d_idle;
              end
            end
          end
          d_ack_a: begin
            cnt_reg <= 4'h0;
            if (rw_reg) begin
              tx_reg <= rd_byte;
              oe_reg <= ~rd_byte[7];
              state_reg <= d_rdata;
            end else begin
              oe_reg <= 1'b0;
              state_reg <= d_reg;
            end
          end
          d_reg: begin
            if (cnt_reg == 4'h8) begin
              ptr_reg <= shift_reg;
              oe_reg <= 1'b1;
              state_reg <= d_ack_r;
            end
          end
          d_ack_r, d_ack_w: begin
            oe_reg <= 1'b0;
            cnt_reg <= 4'h0;
            state_reg <= d_wdata;
          end
          d_wdata: begin
            if (cnt_reg == 4'h8) begin
              ptr_reg <= ptr_reg + 8'h01;
              oe_reg <= 1'b1;
              state_reg <= d_ack_w;
            end
          end
          d_rdata: begin
            if (cnt_reg == 4'h8) begin
              oe_reg <= 1'b0;
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= d_rack;
            end else begin
              oe_reg <= ~tx_reg[6];
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
          d_rack: begin
            if (nack_reg) begin
              state_reg <= d_idle;
            end else begin
              tx_reg <= rd_byte;
              oe_reg <= ~rd_byte[7];
              cnt_reg <= 4'h0;
              state_reg <= d_rdata;
            end
          end
          default: begin
            state_reg <= state_reg;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register file
  // directions reset to all inputs
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dir_reg[0][0] <= `BSSP_DIR_RESET;
      dir_reg[0][1] <= `BSSP_DIR_RESET;
      dir_reg[1][0] <= `BSSP_DIR_RESET;
      dir_reg[1][1] <= `BSSP_DIR_RESET;
      lat_reg[0][0] <= `BSSP_EXP0_LAT_A;
      lat_reg[0][1] <= `BSSP_EXP0_LAT_B;
      lat_reg[1][0] <= `BSSP_EXP1_LAT_A;
      lat_reg[1][1] <= `BSSP_EXP1_LAT_B;
    end else if (wr_en) begin
      // direction registers at 0x00 and 0x01
      if (ptr_reg == `BSSP_REG_DIR_A) begin
        dir_reg[sel_reg][0] <= shift_reg;
      end else if (ptr_reg == `BSSP_REG_DIR_B) begin
        dir_reg[sel_reg][1] <= shift_reg;
      end else if (ptr_reg == `BSSP_REG_LAT_A) begin
        lat_reg[sel_reg][0] <= shift_reg;
      end else if (ptr_reg == `BSSP_REG_LAT_B) begin
        lat_reg[sel_reg][1] <= shift_reg;
      end
    end
  end

  // ==========================================================
  // Pin levels
  // input pins fall back to board pulls
  assign pin_a0 = pin_val(dir_reg[0][0], lat_reg[0][0], `BSSP_EXP0_PULL_A);
  assign pin_b0 = pin_val(dir_reg[0][1], lat_reg[0][1], `BSSP_EXP0_PULL_B);
  assign pin_a1 = pin_val(dir_reg[1][0], lat_reg[1][0], `BSSP_EXP1_PULL_A);
  assign pin_b1 = pin_val(dir_reg[1][1], lat_reg[1][1], `BSSP_EXP1_PULL_B);

  // Switch enables, registered
  // one enable per output bit
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_indicator_light <= 3'h0;
      o_flash_select_switch_enable <= 1'b1;
      o_flash_quad_lane_enable <= 1'b1;
      o_serial_bridge_enable <= 1'b0;
      o_serial_flow_control_enable <= 1'b0;
      o_card_bus_to_connector_enable <= 1'b1;
      o_card_bus_to_memory_enable <= 1'b0;
      o_aux_port_a <= `BSSP_EXP1_PULL_A;
      o_aux_port_b <= `BSSP_EXP1_PULL_B;
    end else begin
      o_indicator_light <= pin_a0[2:0];
      o_flash_select_switch_enable <= pin_a0[`BSSP_BIT_FLASH_SEL];
      o_flash_quad_lane_enable <= pin_a0[`BSSP_BIT_FLASH_QUAD];
      o_serial_bridge_enable <= pin_a0[`BSSP_BIT_SERIAL];
      o_serial_flow_control_enable <= pin_a0[`BSSP_BIT_FLOW];
      o_card_bus_to_connector_enable <= pin_b0[`BSSP_BIT_CARD_CONN];
      o_card_bus_to_memory_enable <= pin_b0[`BSSP_BIT_CARD_MEM];
      o_aux_port_a <= pin_a1;
      o_aux_port_b <= pin_b1;
    end
  end

  // Open-drain: only data is ever pulled low
  assign bus.dev_sda_oe = oe_reg;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_scl_oe = 1'b0;
  assign bus.dev_scl_o = 1'b0;
endmodule

`default_nettype wire

// File: src/bssp_params.svh
// Offsets, addresses, defaults and timing for the board switch port
`ifndef BSSP_PARAMS_SVH
`define BSSP_PARAMS_SVH

// ==========================================================
// Expander register pointers
`define BSSP_REG_DIR_A 8'h00
`define BSSP_REG_DIR_B 8'h01
`define BSSP_REG_LAT_A 8'h12
`define BSSP_REG_LAT_B 8'h13

// ==========================================================
// Two-wire device addresses (7-bit)
`define BSSP_EXP0_ADDR 7'h21
`define BSSP_EXP1_ADDR 7'h22

// ==========================================================
// Reset values
`define BSSP_DIR_RESET 8'hff
`define BSSP_EXP0_LAT_A 8'h02
`define BSSP_EXP0_LAT_B 8'hc4
`define BSSP_EXP1_LAT_A 8'he0
`define BSSP_EXP1_LAT_B 8'hff
// Board pull levels seen while a pin is an input
`define BSSP_EXP0_PULL_A 8'h18
`define BSSP_EXP0_PULL_B 8'h01
`define BSSP_EXP1_PULL_A 8'h00
`define BSSP_EXP1_PULL_B 8'h00

// ==========================================================
// Switch bit positions
`define BSSP_BIT_FLASH_SEL 3
`define BSSP_BIT_FLASH_QUAD 4
`define BSSP_BIT_SERIAL 5
`define BSSP_BIT_FLOW 6
`define BSSP_BIT_CARD_CONN 0
`define BSSP_BIT_CARD_MEM 1

// ==========================================================
// Host controller registers (byte addresses)
`define BSSP_WB_DEV 8'h00
`define BSSP_WB_PTR 8'h04
`define BSSP_WB_WDATA 8'h08
`define BSSP_WB_CMD 8'h0c
`define BSSP_WB_STATUS 8'h10

// ==========================================================
// Timing: system clock and two-wire bit rate in hertz
`define BSSP_CLK_HZ 40000000
`define BSSP_SCL_HZ 100000
`define BSSP_QTR_CYC (`BSSP_CLK_HZ / (4 * `BSSP_SCL_HZ))

`endif

// File: src/bssp_pkg.sv
// Types shared by both ends of the board switch port
`default_nettype none

package bssp_pkg;

  // ==========================================================
  // Expander end states
  typedef enum logic [3:0] {
    d_idle = 4'h0,
    d_addr = 4'h1,
    d_ack_a = 4'h3,
    d_reg = 4'h2,
    d_ack_r = 4'h6,
    d_wdata = 4'h7,
    d_ack_w = 4'h5,
    d_rdata = 4'h4,
    d_rack = 4'hc
  } bssp_dev_state_e;

  // ==========================================================
  // Host end states
  typedef enum logic [1:0] {
    h_idle = 2'h0,
    h_start = 2'h1,
    h_byte = 2'h3,
    h_stop = 2'h2
  } bssp_host_state_e;

endpackage

`default_nettype wire

// File: src/bssp_i2c_if.sv
// Two-wire bus joining the host controller and the expanders
`timescale 1ns/1ps
`default_nettype none

interface bssp_i2c_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // ==========================================================
  // Wired-and with pull-up
  assign scl = ~((host_scl_oe & ~host_scl_o) | (dev_scl_oe & ~dev_scl_o));
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
                output host_sda_oe, input scl, input sda);
  modport dev (output dev_scl_o, output dev_scl_oe, output dev_sda_o,
               output dev_sda_oe, input scl, input sda);
endinterface

`default_nettype wire

// File: src/bssp_tick_div.sv
// Quarter-bit enable divider for the host two-wire engine
`timescale 1ns/1ps
`default_nettype none
`include "bssp_params.svh"

module bssp_tick_div (
  input wire logic i_clock,
  input wire logic i_arst_n,
  output logic o_tick
);
  logic [6:0] cnt_reg;

  // ==========================================================
  // Divider
  // Wraps once per quarter bit
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg <= 7'h00;
      o_tick <= 1'b0;
    end else if (cnt_reg == 7'(`BSSP_QTR_CYC - 1)) begin
      cnt_reg <= 7'h00;
      o_tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
      o_tick <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// File: src/bssp_host_ctrl.sv
// Host end: Wishbone-commanded two-wire master for the expanders
`timescale 1ns/1ps
`default_nettype none
`include "bssp_params.svh"

module bssp_host_ctrl
  import bssp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  bssp_i2c_if.host bus
);
  bssp_host_state_e state_reg;
  logic [6:0] dev_reg;
  logic [7:0] ptr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [2:0] step_reg;
  logic [3:0] bit_reg;
  logic [1:0] ph_reg;
  logic rd_reg;
  logic busy_reg;
  logic nack_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic tick;
  logic wb_hit;
  logic wb_wr;
  logic go;

  // Byte sent at each step: addr-w, pointer, data, addr-r, read (all ones)
  function automatic logic [7:0] tx_for(input logic [2:0] s);
    case (s)
      3'h0: return {dev_reg, 1'b0};
      3'h1: return ptr_reg;
      3'h2: return wdata_reg;
      3'h3: return {dev_reg, 1'b1};
      default: return 8'hff;
    endcase
  endfunction

  bssp_tick_div u_div (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .o_tick(tick)
  );

  // ==========================================================
  // Wishbone slave
  assign wb_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wb_wr = wb_hit & i_wb_we & i_wb_sel[0];
  assign go = wb_wr && (i_wb_adr == `BSSP_WB_CMD) && !busy_reg &&
              (i_wb_dat[0] | i_wb_dat[1]);

  // One-wait-state ack, registered read data
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= wb_hit;
      if (!wb_hit || i_wb_we) begin
        o_wb_dat <= 32'h0000_0000;
      end else if (i_wb_adr == `BSSP_WB_DEV) begin
        o_wb_dat <= {25'h0, dev_reg};
      end else if (i_wb_adr == `BSSP_WB_PTR) begin
        o_wb_dat <= {24'h0, ptr_reg};
      end else if (i_wb_adr == `BSSP_WB_WDATA) begin
        o_wb_dat <= {24'h0, wdata_reg};
      end else if (i_wb_adr == `BSSP_WB_STATUS) begin
        o_wb_dat <= {16'h0, rx_reg, 6'h0, nack_reg, busy_reg};
      end else begin
        o_wb_dat <= 32'h0000_0000;
      end
    end
  end

  // Setup registers, frozen while busy
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dev_reg <= `BSSP_EXP0_ADDR;
      ptr_reg <= 8'h00;
      wdata_reg <= 8'h00;
    end else if (wb_wr && !busy_reg) begin
      if (i_wb_adr == `BSSP_WB_DEV) begin
        dev_reg <= i_wb_dat[6:0];
      end else if (i_wb_adr == `BSSP_WB_PTR) begin
        ptr_reg <= i_wb_dat[7:0];
      end else if (i_wb_adr == `BSSP_WB_WDATA) begin
        wdata_reg <= i_wb_dat[7:0];
      end
    end
  end

  // ==========================================================
  // Two-wire master, four phases per bit
  // only a command write while idle starts a bus transfer
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= h_idle;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      step_reg <= 3'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      rd_reg <= 1'b0;
      busy_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (state_reg == h_idle) begin
      if (go) begin
        state_reg <= h_start;
        ph_reg <= 2'h0;
        step_reg <= 3'h0;
        rd_reg <= i_wb_dat[1];
        busy_reg <= 1'b1;
        nack_reg <= 1'b0;
      end
    end else if (tick) begin
      ph_reg <= ph_reg + 2'h1;
      case (state_reg)
        h_start: begin
          if (ph_reg == 2'h0) sda_oe_reg <= 1'b0;
          if (ph_reg == 2'h1) scl_oe_reg <= 1'b0;
          if (ph_reg == 2'h2) sda_oe_reg <= 1'b1;
          if (ph_reg == 2'h3) begin
            scl_oe_reg <= 1'b1;
            bit_reg <= 4'h0;
            tx_reg <= tx_for(step_reg);
            state_reg <= h_byte;
          end
        end
        h_byte: begin
          if (ph_reg == 2'h0) begin
            sda_oe_reg <= (bit_reg != 4'h8) && (step_reg != 3'h4) &&
                          !tx_reg[7];
          end
          if (ph_reg == 2'h1) scl_oe_reg <= 1'b0;
          if (ph_reg == 2'h2) begin
            if (bit_reg == 4'h8 && step_reg != 3'h4 && bus.sda) begin
              nack_reg <= 1'b1;
            end
            if (bit_reg != 4'h8 && step_reg == 3'h4) begin
              rx_reg <= {rx_reg[6:0], bus.sda};
            end
          end
          if (ph_reg == 2'h3) begin
            scl_oe_reg <= 1'b1;
            tx_reg <= {tx_reg[6:0], 1'b0};
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'h8) begin
              // pointer then data, or restart to read
              if (nack_reg || step_reg == 3'h2 || step_reg == 3'h4) begin
                state_reg <= h_stop;
              end else if (step_reg == 3'h1 && rd_reg) begin
                step_reg <= 3'h3;
                state_reg <= h_start;
              end else begin
                step_reg <= step_reg + 3'h1;
                bit_reg <= 4'h0;
                tx_reg <= tx_for(step_reg + 3'h1);
              end
            end
          end
        end
        h_stop: begin
          if (ph_reg == 2'h0) sda_oe_reg <= 1'b1;
          if (ph_reg == 2'h1) scl_oe_reg <= 1'b0;
          if (ph_reg == 2'h2) sda_oe_reg <= 1'b0;
          if (ph_reg == 2'h3) begin
            busy_reg <= 1'b0;
            state_reg <= h_idle;
          end
        end
        default: begin
          state_reg <= h_idle;
        end
      endcase
    end
  end

  assign bus.host_scl_oe = scl_oe_reg;
  assign bus.host_sda_oe = sda_oe_reg;
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
endmodule

`default_nettype wire

// File: verif/bssp_monitor.sv
// Protocol checks on the two-wire bus joining host and expanders
`timescale 1ns/1ps
`default_nettype none

module bssp_monitor (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking mon_cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);

  // ==========================================================
  // Host has let go of data whenever the expander pulls it with the clock high
  AST_HOST_YIELDS_DATA: assert property (
    dev_sda_oe && scl |-> !host_sda_oe)
    else $error("host and expander both drive data");
  // Expander starts pulling data only with the clock low
  AST_DEV_STARTS_LOW: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("expander drove data with clock high");
  // Bus idle right after reset
  AST_IDLE_AFTER_RESET: assert property ($rose(i_arst_n) |-> scl && sda)
    else $error("bus busy after reset");
  // ==========================================================
  // Clock phase lengths
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase too short");
  AST_SCL_LOW_MIN: assert property ($fell(scl) |-> (!scl)[*8])
    else $error("clock low phase too short");
  // Expander data only moves while the clock is low
  AST_DEV_SDA_STEADY: assert property (
    scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("expander moved data with clock high");
  // Start is followed by clocking, stop by idle
  AST_START_CLOCKS: assert property (
    $fell(sda) && scl |-> ##[1:400] !scl)
    else $error("no clock after start");
  AST_STOP_IDLE: assert property (
    $rose(sda) && scl |-> ##1 (scl && sda)[*8])
    else $error("bus not idle after stop");
endmodule

`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench: host controller and expanders joined by the bus
`timescale 1ns/1ps
`default_nettype none
`include "bssp_params.svh"

module testbench;
  typedef struct packed {
    logic [6:0] dev;
    logic [7:0] ptr;
    logic [7:0] dat;
  } bssp_row_s;
  logic i_clock;
  logic i_arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h1;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [2:0] light;
  logic fsel, quad, ser, flow, conn, mem;
  logic [7:0] aux_a, aux_b;
  logic [31:0] rd;
  logic [7:0] m [8];
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // Ordinary writes: dir A, latch A, dir B, latch B, far expander dir A
  bssp_row_s rows [5] = '{'{7'h21, `BSSP_REG_DIR_A, 8'h00},
    '{7'h21, `BSSP_REG_LAT_A, 8'h6d}, '{7'h21, `BSSP_REG_DIR_B, 8'hfc},
    '{7'h21, `BSSP_REG_LAT_B, 8'h02}, '{7'h22, `BSSP_REG_DIR_A, 8'h0f}};

  bssp_i2c_if i_bssp_i2c_if ();
  bssp_host_ctrl i_bssp_host_ctrl (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .bus(i_bssp_i2c_if));
  bssp_switch_port i_bssp_switch_port (.i_clock(i_clock),
    .i_arst_n(i_arst_n), .bus(i_bssp_i2c_if), .o_indicator_light(light),
    .o_flash_select_switch_enable(fsel), .o_flash_quad_lane_enable(quad),
    .o_serial_bridge_enable(ser), .o_serial_flow_control_enable(flow),
    .o_card_bus_to_connector_enable(conn),
    .o_card_bus_to_memory_enable(mem), .o_aux_port_a(aux_a),
    .o_aux_port_b(aux_b));
  bssp_monitor i_bssp_monitor (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .host_scl_o(i_bssp_i2c_if.host_scl_o),
    .host_scl_oe(i_bssp_i2c_if.host_scl_oe),
    .host_sda_o(i_bssp_i2c_if.host_sda_o),
    .host_sda_oe(i_bssp_i2c_if.host_sda_oe),
    .dev_scl_o(i_bssp_i2c_if.dev_scl_o),
    .dev_scl_oe(i_bssp_i2c_if.dev_scl_oe),
    .dev_sda_o(i_bssp_i2c_if.dev_sda_o),
    .dev_sda_oe(i_bssp_i2c_if.dev_sda_oe),
    .scl(i_bssp_i2c_if.scl), .sda(i_bssp_i2c_if.sda));

  // ==========================================================
  // Clock and timeout
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 96000) begin
      n_errors++;
      $display("Error at %0t: run timed out", $time);
      report_and_stop();
    end
  end

  // ==========================================================
  // Pin level: latch where direction is 0, board pull elsewhere
  function automatic logic [7:0] pin(int k, logic [7:0] pull);
    return (m[k+2] & ~m[k]) | (pull & m[k]);
  endfunction
  // Switch outputs against the register model
  task automatic chk_out();
    logic [7:0] a, b;
    logic [24:0] got, exp;
    a = pin(0, `BSSP_EXP0_PULL_A);
    b = pin(1, `BSSP_EXP0_PULL_B);
    got = {light, fsel, quad, ser, flow, conn, mem, aux_a, aux_b};
    exp = {a[2:0], a[3], a[4], a[5], a[6], b[0], b[1],
      pin(4, `BSSP_EXP1_PULL_A), pin(5, `BSSP_EXP1_PULL_B)};
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: outputs %h, expected %h", $time, got, exp);
    end
  endtask
  // Bus data against an expected word
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask
  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge i_clock); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // One two-wire transfer, then poll until idle; rd keeps last status
  task automatic xfer(input logic [6:0] dv, input logic [7:0] p,
    input logic [7:0] d, input logic rdop);
    wb(1'b1, `BSSP_WB_DEV, {25'h0, dv}, rd);
    wb(1'b1, `BSSP_WB_PTR, {24'h0, p}, rd);
    wb(1'b1, `BSSP_WB_WDATA, {24'h0, d}, rd);
    wb(1'b1, `BSSP_WB_CMD, rdop ? 32'h2 : 32'h1, rd);
    do wb(1'b0, `BSSP_WB_STATUS, 32'h0, rd); while (rd[0] !== 1'b0);
    repeat (2) @(posedge i_clock);
  endtask
  task automatic done_test(input string s);
    $display("Test %s done", s);
  endtask
  // Register model back to its reset values
  task automatic init_model();
    m = '{`BSSP_DIR_RESET, `BSSP_DIR_RESET, `BSSP_EXP0_LAT_A,
      `BSSP_EXP0_LAT_B, `BSSP_DIR_RESET, `BSSP_DIR_RESET,
      `BSSP_EXP1_LAT_A, `BSSP_EXP1_LAT_B};
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    init_model();
    repeat (6) @(posedge i_clock);
    chk_out();
    i_arst_n <= 1'b1;
    @(negedge i_clock);
    chk_out();
    done_test("reset");
    foreach (rows[i]) begin
      xfer(rows[i].dev, rows[i].ptr, rows[i].dat, 1'b0);
      m[{rows[i].dev[1], rows[i].ptr[4], rows[i].ptr[0]}] = rows[i].dat;
      chk_out();
      done_test("row");
    end
    // Read back an untouched latch of the far expander
    xfer(7'h22, `BSSP_REG_LAT_A, 8'h00, 1'b1);
    chk_val({24'h0, rd[15:8]}, {24'h0, `BSSP_EXP1_LAT_A});
    chk_val({31'h0, rd[1]}, 32'h0);
    done_test("read");
    // Nobody answers this address: nack, outputs unchanged
    xfer(7'h23, `BSSP_REG_DIR_A, 8'hff, 1'b0);
    chk_val({31'h0, rd[1]}, 32'h1);
    chk_out();
    done_test("nack");
    // Unmapped controller address reads zero
    wb(1'b0, 8'h20, 32'h0, rd);
    chk_val(rd, 32'h0);
    done_test("unmapped");
    // Mid-run reset: pins back to inputs, far port B latch at default
    i_arst_n <= 1'b0;
    init_model();
    repeat (2) @(posedge i_clock);
    i_arst_n <= 1'b1;
    @(negedge i_clock);
    chk_out();
    xfer(7'h22, `BSSP_REG_DIR_B, 8'h00, 1'b0);
    m[5] = 8'h00;
    chk_out();
    done_test("mid-run reset");
    report_and_stop();
  end
endmodule

`default_nettype wire
